// ===== hw/fra_pkt_counter.v
`timescale 1ns/10ps
`include "fra_consts.vh"

// ----------------------------------------------------------------
// per-port saturating packet counter
// ----------------------------------------------------------------
module fra_pkt_counter #(
  parameter CNT_W = `FRA_CNT_W
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire frame_done_i,
  output reg [CNT_W-1:0] count_o
);

  // clear wins: a frame ending in the clear cycle is counted in the new interval
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      count_o <= {CNT_W{1'b0}};
    else if (clear_i)
      count_o <= frame_done_i ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}}; // R5
    else if (frame_done_i && (count_o != {CNT_W{1'b1}}))
      count_o <= count_o + {{(CNT_W-1){1'b0}}, 1'b1}; // R10
  end

endmodule

// ===== hw/fra_switch.v
`timescale 1ns/10ps
`include "fra_consts.vh"

// Notes on behaviour
// R1: four 100 Mb/s ports: three ingress from acquisition units, one egress.
// R2: every ingress packet goes to egress by a fixed table, no setup.
// R3: time protocol messages pass through unaltered like all data.
// R4: one packet counter per port, four in all.
// R5: all counters clear to zero once each second; a counter whose frame ends in the clear cycle restarts at one.
// R6: no own address; never answers ping or address-resolution requests.
// R7: ping and address-resolution requests are forwarded like other traffic.
// R8: integrator cascades at most two switches between source and aggregator.
// R9: stand-alone host programs through the unused ingress port.
// R10: count once per complete valid frame, saturating at full scale; egress counts one when a sent and a received frame end together.
// R11: one-second tick from free-running divider starting at reset release.

module fra_switch #(
  parameter DATA_W = `FRA_DATA_W,
  parameter CNT_W = `FRA_CNT_W,
  parameter CLEAR_CYCLES = `FRA_CLEAR_CYCLES
) (
  input wire sys_clk_i,
  input wire rst_i,
  // ingress port streams, one lane each, from the port mac side
  input wire [3*DATA_W-1:0] in_data_i,
  input wire [2:0] in_valid_i,
  input wire [2:0] in_sof_i,
  input wire [2:0] in_eof_i,
  input wire [2:0] in_err_i,
  // egress port stream
  output reg [DATA_W-1:0] out_data_o,
  output reg out_valid_o,
  output reg out_sof_o,
  output reg out_eof_o,
  output reg out_err_o,
  // arbitration grant fed back to ingress macs; stall when low
  output reg [2:0] in_ready_o,
  // frames received on the egress port (counted only, never answered)
  input wire eg_rx_eof_i,
  input wire eg_rx_err_i,
  // per-port counters and the one-second tick
  output reg [CNT_W-1:0] cnt0_o,
  output reg [CNT_W-1:0] cnt1_o,
  output reg [CNT_W-1:0] cnt2_o,
  output reg [CNT_W-1:0] cnt3_o,
  output reg tick_o
);

  // --------------------------------------------------------------
  // one-second divider
  // --------------------------------------------------------------
  localparam [31:0] TICK_LAST = CLEAR_CYCLES - 1;
  reg [31:0] div_r;
  reg tick_nxt;

  // free running from reset release, no software control
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      div_r <= 32'h00000000;
    else if (div_r == TICK_LAST)
      div_r <= 32'h00000000; // R11
    else
      div_r <= div_r + 32'h00000001;
  end

  always @*
  begin
    tick_nxt = (div_r == TICK_LAST); // R11
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      tick_o <= 1'b0;
    else
      tick_o <= tick_nxt;
  end

  // --------------------------------------------------------------
  // frame-level arbiter toward egress
  // --------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_XFER = 3'h2;
  localparam [2:0] ST_GAP = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] owner_r;
  reg [1:0] owner_nxt;
  reg [1:0] last_r;
  reg [1:0] last_nxt;

  // round robin after the last owner so no ingress port starves
  function [1:0] pick;
    input [2:0] req;
    input [1:0] last;
    reg [1:0] p;
    begin
      p = 2'h3;
      case (last)
        2'h0: p = req[1] ? 2'h1 : (req[2] ? 2'h2 : (req[0] ? 2'h0 : 2'h3));
        2'h1: p = req[2] ? 2'h2 : (req[0] ? 2'h0 : (req[1] ? 2'h1 : 2'h3));
        default: p = req[0] ? 2'h0 : (req[1] ? 2'h1 : (req[2] ? 2'h2 : 2'h3));
      endcase
      pick = p;
    end
  endfunction

  // frames are forwarded whole and byte for byte; no content inspection, so
  // time protocol, ping and address-resolution frames all pass untouched
  wire [DATA_W-1:0] sel_data = in_data_i[owner_r*DATA_W +: DATA_W]; // R3
  wire sel_valid = in_valid_i[owner_r];
  wire sel_eof = in_eof_i[owner_r];
  wire [1:0] cand = pick(in_valid_i & in_sof_i, last_r);

  always @*
  begin
    state_nxt = state_r;
    owner_nxt = owner_r;
    last_nxt = last_r;
    case (state_r)
      ST_IDLE:
      begin
        if (cand != 2'h3)
        begin
          owner_nxt = cand; // R2
          last_nxt = cand;
          state_nxt = ST_XFER;
        end
      end
      ST_XFER:
      begin
        if (sel_valid && sel_eof && in_ready_o[owner_r])
          state_nxt = ST_GAP;
      end
      ST_GAP:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      owner_r <= 2'h0;
      last_r <= 2'h2;
    end
    else
    begin
      state_r <= state_nxt;
      owner_r <= owner_nxt;
      last_r <= last_nxt;
    end
  end

  // grant only the owner while transferring; the egress has no receive
  // path into any reply logic, so the switch itself never answers anything
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      in_ready_o <= 3'h0;
    else if (state_nxt == ST_XFER && !(state_r == ST_XFER && sel_valid && sel_eof && in_ready_o[owner_r]))
      in_ready_o <= 3'h1 << owner_nxt; // R2
    else
      in_ready_o <= 3'h0;
  end

  // egress register stage: one cycle latency, every ingress frame lands here
  wire take = (state_r == ST_XFER) && sel_valid && in_ready_o[owner_r];

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      out_data_o <= {DATA_W{1'b0}};
      out_valid_o <= 1'b0;
      out_sof_o <= 1'b0;
      out_eof_o <= 1'b0;
      out_err_o <= 1'b0;
    end
    else
    begin
      out_data_o <= take ? sel_data : {DATA_W{1'b0}}; // R7
      out_valid_o <= take; // R1
      out_sof_o <= take & in_sof_i[owner_r];
      out_eof_o <= take & sel_eof;
      out_err_o <= take & in_err_i[owner_r];
    end
  end

  // --------------------------------------------------------------
  // per-port packet counters
  // --------------------------------------------------------------
  wire [3:0] done;
  wire [CNT_W-1:0] cnt_w0;
  wire [CNT_W-1:0] cnt_w1;
  wire [CNT_W-1:0] cnt_w2;
  wire [CNT_W-1:0] cnt_w3;

  // ingress counts frames it accepts whole and error free
  assign done[0] = take && owner_r == 2'h0 && sel_eof && !in_err_i[0]; // R10
  assign done[1] = take && owner_r == 2'h1 && sel_eof && !in_err_i[1];
  assign done[2] = take && owner_r == 2'h2 && sel_eof && !in_err_i[2];
  // egress counts frames sent and frames received, but only one when both end in the same cycle
  assign done[3] = (out_valid_o && out_eof_o && !out_err_o) || (eg_rx_eof_i && !eg_rx_err_i); // R6

  fra_pkt_counter #(.CNT_W(CNT_W)) u_cnt0 (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clear_i(tick_o),
    .frame_done_i(done[0]), .count_o(cnt_w0)); // R4
  fra_pkt_counter #(.CNT_W(CNT_W)) u_cnt1 (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clear_i(tick_o),
    .frame_done_i(done[1]), .count_o(cnt_w1));
  fra_pkt_counter #(.CNT_W(CNT_W)) u_cnt2 (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clear_i(tick_o),
    .frame_done_i(done[2]), .count_o(cnt_w2));
  fra_pkt_counter #(.CNT_W(CNT_W)) u_cnt3 (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clear_i(tick_o),
    .frame_done_i(done[3]), .count_o(cnt_w3));

  // outputs come from flip-flops, so the counters appear one cycle later
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cnt0_o <= `FRA_CNT_RST;
      cnt1_o <= `FRA_CNT_RST;
      cnt2_o <= `FRA_CNT_RST;
      cnt3_o <= `FRA_CNT_RST;
    end
    else
    begin
      cnt0_o <= cnt_w0; // R5
      cnt1_o <= cnt_w1;
      cnt2_o <= cnt_w2;
      cnt3_o <= cnt_w3;
    end
  end

endmodule

// ===== inc/fra_consts.vh
`ifndef FRA_CONSTS_VH
`define FRA_CONSTS_VH
// port numbering: three ingress ports then the egress port
`define FRA_NUM_PORTS 4
`define FRA_NUM_INGRESS 3
`define FRA_EGRESS_PORT 3
// byte lane and counter widths
`define FRA_DATA_W 8
`define FRA_CNT_W 16
// clock and clear interval
`define FRA_CLK_HZ 100000000
`define FRA_CLEAR_PERIOD_S 1
`define FRA_CLEAR_CYCLES (`FRA_CLK_HZ * `FRA_CLEAR_PERIOD_S)
// reset values
`define FRA_CNT_RST 16'h0000
`endif

// ===== sim/fra_src.sv
`timescale 1ns/10ps
// ----------------
// ingress mac model
// ----------------
module fra_src (
  input wire clk_i,
  input wire [2:0] go_i,
  input wire [2:0] rdy_i,
  output reg [23:0] dat_o = 24'h0,
  output reg [2:0] vld_o = 3'h0,
  output reg [2:0] sof_o = 3'h0,
  output reg [2:0] eof_o = 3'h0
);
  reg [2:0] tk_r = 3'h0;
  reg [2:0] go_r = 3'h0;
  integer p;
  // a byte is gone only at an edge that saw ready high
  always @(posedge clk_i)
  begin
    tk_r <= vld_o & rdy_i;
    go_r <= go_i;
  end
  // three-byte frames; a released lane shows inverted data, never the last byte
  always @(negedge clk_i)
    for (p = 0; p < 3; p = p + 1)
      if (tk_r[p] && eof_o[p])
      begin
        vld_o[p] <= 1'b0;
        eof_o[p] <= 1'b0;
        dat_o[8*p+:8] <= ~dat_o[8*p+:8];
      end
      else if (tk_r[p])
      begin
        sof_o[p] <= 1'b0;
        eof_o[p] <= dat_o[8*p+:2] == 2'h1;
        dat_o[8*p+:8] <= dat_o[8*p+:8] + 8'h01;
      end
      else if (go_r[p] && !vld_o[p])
      begin
        vld_o[p] <= 1'b1;
        sof_o[p] <= 1'b1;
        dat_o[8*p+:8] <= {4'hA + p[3:0], 4'h0};
      end
endmodule

// ===== sim/fra_switch_asserts.sv
`timescale 1ns/10ps
// ----------------
// switch port checker
// ----------------
module fra_switch_asserts #(
  parameter CLEAR_CYCLES = 100
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [23:0] in_data_i,
  input wire [2:0] in_valid_i,
  input wire [2:0] in_ready_o,
  input wire [7:0] out_data_o,
  input wire out_valid_o,
  input wire out_sof_o,
  input wire out_eof_o,
  input wire [15:0] cnt0_o,
  input wire [15:0] cnt3_o,
  input wire tick_o
);
  reg [31:0] gap_r = 32'h0;
  reg seen_r = 1'b0;
  wire tk = |(in_valid_i & in_ready_o);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // cycles since last tick; the first interval is left unjudged
  always @(posedge sys_clk_i)
  begin
    gap_r <= (rst_i || tick_o) ? 32'h0 : gap_r + 32'h1;
    seen_r <= !rst_i && (seen_r || tick_o);
  end
  property p_sof; out_sof_o |-> out_valid_o; endproperty
  a_sof: assert property (p_sof) else $error("sof alone");
  property p_gnt; $onehot0(in_ready_o); endproperty
  a_gnt: assert property (p_gnt) else $error("two grants");
  property p_fwd; in_valid_i[0] && in_ready_o[0] |=> out_valid_o && out_data_o == $past(in_data_i[7:0]); endproperty
  a_fwd: assert property (p_fwd) else $error("byte altered");
  property p_own; out_valid_o |-> $past(tk); endproperty
  a_own: assert property (p_own) else $error("own byte");
  property p_eof; out_eof_o |-> in_ready_o == 3'h0; endproperty
  a_eof: assert property (p_eof) else $error("grant kept");
  property p_per; tick_o && seen_r |-> gap_r == CLEAR_CYCLES - 1; endproperty
  a_per: assert property (p_per) else $error("tick period");
  // the counters clear one edge after the tick and reach the outputs one edge later
  property p_clr; tick_o |-> ##2 (cnt0_o <= 16'h1 && cnt3_o <= 16'h1); endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  // the drop to zero shows two edges after the tick, so that step is exempt
  property p_step; !$past(tick_o) |=> (cnt3_o - $past(cnt3_o)) <= 16'h1; endproperty
  a_step: assert property (p_step) else $error("count jump");
  c_eof: cover property (out_eof_o);
  c_tick: cover property (tick_o);
  c_gnt2: cover property (in_ready_o == 3'h4);
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
// ----------------
// switch bench
// ----------------
module testbench;
  localparam CC = 100;
  reg sys_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg eg_eof = 1'b0;
  reg eg_err = 1'b0;
  reg [2:0] go = 3'h0;
  reg [2:0] ierr = 3'h0;
  wire [23:0] d;
  wire [2:0] v, s, e, rdy;
  wire [7:0] od;
  wire ov, os, oe, oerr, tick;
  wire [15:0] c0, c1, c2, c3;
  integer fails = 0;
  integer checks = 0;
  integer t;
  reg [10:0] q[$];
  always #5 sys_clk_i = ~sys_clk_i;
  // one switch between the sources and the aggregator, inside the cascade limit
  fra_switch #(.CLEAR_CYCLES(CC)) u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_data_i(d), .in_valid_i(v),
    .in_sof_i(s), .in_eof_i(e), .in_err_i(ierr), .out_data_o(od), .out_valid_o(ov), .out_sof_o(os),
    .out_eof_o(oe), .out_err_o(oerr), .in_ready_o(rdy), .eg_rx_eof_i(eg_eof), .eg_rx_err_i(eg_err),
    .cnt0_o(c0), .cnt1_o(c1), .cnt2_o(c2), .cnt3_o(c3), .tick_o(tick));
  fra_src u_src (.clk_i(sys_clk_i), .go_i(go), .rdy_i(rdy), .dat_o(d), .vld_o(v), .sof_o(s), .eof_o(e));
  // log each egress byte with its flags at the falling edge, where the outputs have settled
  always @(negedge sys_clk_i)
    if (ov)
      q.push_back({oerr, os, oe, od});
  task chk(input [47:0] nm, input [15:0] ex, input [15:0] got);
  begin
    checks = checks + 1;
    if (got !== ex)
    begin
      fails = fails + 1;
      $display("unexpected %s exp %h got %h", nm, ex, got);
    end
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // bounded waits: for n logged bytes, or for the next tick
  task wait_q(input integer n);
    integer k;
  begin
    for (k = 0; k < 60 && q.size() < n; k = k + 1)
      @(negedge sys_clk_i);
    chk("qsize", n, q.size());
    if (q.size() < n)
      end_sim;
  end
  endtask
  task wait_tick;
  begin
    for (t = 0; !tick && t < 2*CC; t = t + 1)
      @(negedge sys_clk_i);
    if (t >= 2*CC)
      chk("tick", 1, 0);
    if (t >= 2*CC)
      end_sim;
    // two more edges: the clear, then the registered counter outputs
    repeat (2) @(negedge sys_clk_i);
  end
  endtask
  task frame(input [3:0] p, input er);
    integer k;
  begin
    for (k = 0; k < 3; k = k + 1)
      chk("byte", {er, k == 0, k == 2, 4'hA + p, k[3:0]}, q.pop_front());
  end
  endtask
  task send(input [2:0] m);
  begin
    @(negedge sys_clk_i);
    go = m;
    @(negedge sys_clk_i);
    go = 3'h0;
    repeat (30) @(negedge sys_clk_i);
  end
  endtask
  // a bad frame is forwarded with its error mark but counted nowhere
  task sc_bad;
  begin
    wait_tick;
    ierr = 3'h1;
    send(3'h1);
    ierr = 3'h0;
    wait_q(3);
    frame(0, 1'b1);
    chk("cnt0", 0, c0);
    chk("cnt3", 0, c3);
  end
  endtask
  task sc_one;
  begin
    wait_tick;
    send(3'h1);
    wait_q(3);
    frame(0, 1'b0);
    chk("cnt0", 1, c0);
    chk("cnt3", 1, c3);
  end
  endtask
  // two ports at once: whole frames in turn, the spare port 0 idle and uncounted
  task sc_rr;
  begin
    wait_tick;
    send(3'h6);
    wait_q(6);
    frame(1, 1'b0);
    frame(2, 1'b0);
    chk("cnt0", 0, c0);
    chk("cnt1", 1, c1);
    chk("cnt2", 1, c2);
    chk("cnt3", 2, c3);
  end
  endtask
  // frames arriving at egress are counted, bad ones not, none answered
  task sc_egr;
  begin
    wait_tick;
    eg_eof = 1'b1;
    eg_err = 1'b1;
    @(negedge sys_clk_i);
    eg_eof = 1'b0;
    eg_err = 1'b0;
    @(negedge sys_clk_i);
    eg_eof = 1'b1;
    @(negedge sys_clk_i);
    eg_eof = 1'b0;
    repeat (30) @(negedge sys_clk_i);
    chk("cnt3", 1, c3);
    chk("qsize", 0, q.size());
    wait_tick;
    chk("cnt3", 0, c3);
    // the count starts two cycles after the previous tick
    wait_tick;
    chk("period", CC - 2, t);
  end
  endtask
  initial
  begin
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    sc_bad;
    sc_one;
    sc_rr;
    sc_egr;
    end_sim;
  end
endmodule
bind fra_switch fra_switch_asserts #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_chk (.sys_clk_i, .rst_i, .in_data_i,
  .in_valid_i, .in_ready_o, .out_data_o, .out_valid_o, .out_sof_o, .out_eof_o, .cnt0_o, .cnt3_o, .tick_o);
